// ### shared/wmc_params.svh
// register map, field positions, reset values and timing counts
`ifndef WMC_PARAMS_SVH
`define WMC_PARAMS_SVH
// register indices; byte address is four times the index
`define WMC_IDX_PCTL      10'h014
`define WMC_IDX_PFLG      10'h015
`define WMC_IDX_WCTL      10'h016
`define WMC_IDX_RESTART   10'h017
`define WMC_IDX_SLOW      10'h018
// restart keys
`define WMC_KEY_FIRST     8'h55
`define WMC_KEY_SECOND    8'haa
// periodic_irq_control fields
`define WMC_PC_IE         7
`define WMC_PC_SWAI       6
`define WMC_PC_SDBG       5
`define WMC_PC_BYP        3
// periodic_irq_flag field
`define WMC_PF_FLAG       7
// watchdog_monitor_control fields
`define WMC_WC_CME        7
`define WMC_WC_MONITOR_FORCE_ON       6
`define WMC_WC_FORCE      5
`define WMC_WC_WIN        4
`define WMC_WC_SUPERVISOR_RESET_DISABLE       3
// reset values
`define WMC_RST_RATE      3'h7
`define WMC_RST_SLOW      6'h00
// clock monitor delay, shortest figure of the range
`define WMC_CLK_NS        10
`define WMC_MON_NS        2000
`define WMC_MON_CYC       ((`WMC_MON_NS + `WMC_CLK_NS - 1) / `WMC_CLK_NS)
`endif

// ### shared/wmc_pkg.sv
// types of the watchdog, periodic timer and clock monitor block
package wmc_pkg;
    typedef struct packed {
        logic [2:0]  xsy;
        logic        xlv;
        logic [2:0]  psy;
        logic        plv;
        logic [6:0]  slow_cnt;
        logic        slow_half;
        logic [5:0]  slow_div;
        logic [12:0] pre;
        logic [5:0]  rti_cnt;
        logic [9:0]  wd_cnt;
        logic        armed;
        logic        flag;
        logic        periodic_irq_enable;
        logic        swai;
        logic        sdbg;
        logic        byp;
        logic [2:0]  rtr;
        logic        monitor_enable;
        logic        monitor_force_on;
        logic        force_rst;
        logic        windowed_watchdog;
        logic        supervisor_reset_disable;
        logic [2:0]  cr;
        logic        once_p;
        logic        once_w;
        logic        init;
        logic [7:0]  mon_cnt;
        logic        mon_fail;
        logic        limp;
        logic        wd_rst;
        logic        cm_rst;
        logic [31:0] prdata;
    } wmc_state_s;
endpackage : wmc_pkg

// ### logic/wmc_supervisor.sv
// watchdog, periodic interrupt timer and clock monitor behind apb
`timescale 1ns/1ps
`include "wmc_params.svh"

// Behaviour
// R1: when enabled, keys 55 then aa must come before period end, else reset.
// R2: any other value written to the restart port resets at once.
// R3: windowed mode: restart write before last quarter resets; bit write-once.
// R4: in window 55 may repeat; aa restarts and closes the window.
// R5: watchdog restart leaves the shared prescaler running.
// R6: watchdog rate 0 off, else 2^13,15,17,19,21,22,23; write-once.
// R7: periodic rate 0 off, else 2^13 to 2^19; writable anytime.
// R8: flag sets every period; enabled flag requests an interrupt.
// R9: writing one to the flag bit clears it; zero leaves it.
// R10: stop-in-wait halts both timers in wait; write-once.
// R11: stop-in-debug halts both timers in debug; write-once.
// R12: bypass makes prescaler divide by 4; special modes only.
// R13: no crystal edge within monitor delay gives reset or limp-home.
// R14: force-monitor is write-once and keeps the monitor on until reset.
// R15: monitor enable loads pll supply sense level at reset.
// R16: special-only force bit fires enabled resets unless disabled.
// R17: reset-disable blocks both failure resets; special modes only.
// R18: timebase is slow clock over two; slow is crystal over 2*n.
// R19: in limp-home the timebase comes from the pll clock.
// R20: a completed key pair restarts the watchdog count from zero.
module wmc_supervisor (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_clock,
    input  wire logic        pll_output_clock,
    input  wire logic        pll_supply_sense,
    input  wire logic        special_mode,
    input  wire logic        wait_state,
    input  wire logic        debug_state,
    input  wire logic        no_limp_home,
    output logic             watchdog_reset,
    output logic             monitor_reset,
    output logic             limp_home,
    output logic             periodic_irq_request
);
    import wmc_pkg::*;

    localparam logic [7:0] MON_LAST = 8'(`WMC_MON_CYC - 1);

    wmc_state_s q;
    wmc_state_s n;

    logic       xrise, prise, src, slow_tick, tb_tick, stop, pre_tick;
    logic       rti_hit, wd_en, wd_last, in_win, wd_fire, cm_fire;
    logic       mact, mon_new, setup, wr, mapped, rs_wr;
    logic [9:0] idx;
    logic [7:0] wb;

    // last watchdog count, in prescaler ticks of 2^13 timebase
    function automatic logic [9:0] wd_top(input logic [2:0] r);
        case (r)
            3'h1:    wd_top = 10'h000;
            3'h2:    wd_top = 10'h003;
            3'h3:    wd_top = 10'h00f;
            3'h4:    wd_top = 10'h03f;
            3'h5:    wd_top = 10'h0ff;
            3'h6:    wd_top = 10'h1ff;
            3'h7:    wd_top = 10'h3ff;
            default: wd_top = 10'h000;
        endcase
    endfunction : wd_top

    // periodic count mask, 2^(r-1) prescaler ticks per period
    function automatic logic [5:0] rti_mask(input logic [2:0] r);
        rti_mask = 6'((7'h01 << (r - 3'h1)) - 7'h01);
    endfunction : rti_mask

    assign pready               = 1'b1;
    assign prdata               = q.prdata;
    assign watchdog_reset       = q.wd_rst;
    assign monitor_reset        = q.cm_rst;
    assign limp_home            = q.limp;
    assign periodic_irq_request = q.flag & q.periodic_irq_enable; // R8

    assign idx     = paddr[11:2];
    assign mapped  = (paddr[1:0] == 2'h0) &&
                     (idx >= `WMC_IDX_PCTL) && (idx <= `WMC_IDX_SLOW);
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & pstrb[0] & mapped;
    assign pslverr = psel & penable & ~mapped;
    assign wb      = pwdata[7:0];
    assign rs_wr   = wr && (idx == `WMC_IDX_RESTART);

    always_comb
    begin
        n        = q;
        n.wd_rst = 1'b0;
        n.cm_rst = 1'b0;
        n.init   = 1'b1;
        wd_fire  = 1'b0;
        cm_fire  = 1'b0;

        // pin sync: change counts once stages two and three agree
        n.xsy = {q.xsy[1:0], crystal_clock};
        n.psy = {q.psy[1:0], pll_output_clock};
        xrise = (q.xsy[1] == q.xsy[2]) & q.xsy[2] & ~q.xlv;
        prise = (q.psy[1] == q.psy[2]) & q.psy[2] & ~q.plv;
        if (q.xsy[1] == q.xsy[2])
            n.xlv = q.xsy[2];
        if (q.psy[1] == q.psy[2])
            n.plv = q.psy[2];

        // reset-time captures, taken on the first edge after release
        if (!q.init)
        begin
            n.monitor_enable  = pll_supply_sense; // R15
            n.supervisor_reset_disable = special_mode;
        end

        src       = q.limp ? prise : xrise; // R19
        slow_tick = 1'b0;
        if (src)
        begin
            if (q.slow_div == 6'h00)
                slow_tick = 1'b1; // R18
            // at or past the end: a lowered divider acts within one period
            else if (q.slow_cnt >= 7'({q.slow_div, 1'b0} - 7'h01))
            begin
                slow_tick  = 1'b1;
                n.slow_cnt = 7'h00;
            end
            else
                n.slow_cnt = q.slow_cnt + 7'h01;
        end
        tb_tick = slow_tick & q.slow_half; // R18
        if (slow_tick)
            n.slow_half = ~q.slow_half;

        stop = (wait_state & q.swai) | (debug_state & q.sdbg); // R10 R11
        // prescaler is never cleared by a restart, hence its jitter
        pre_tick = 1'b0;
        if (tb_tick && !stop)
        begin
            n.pre    = q.pre + 13'h0001; // R5
            pre_tick = q.byp ? (q.pre[1:0] == 2'h3) : (&q.pre); // R12
        end

        rti_hit = pre_tick && (q.rtr != 3'h0) &&
                  ((q.rti_cnt & rti_mask(q.rtr)) == rti_mask(q.rtr)); // R7
        if (pre_tick)
            n.rti_cnt = q.rti_cnt + 6'h01;

        wd_en   = (q.cr != 3'h0); // R6
        wd_last = (q.wd_cnt == wd_top(q.cr));
        in_win  = ({1'b0, q.wd_cnt} >=
                   11'({1'b0, wd_top(q.cr)} + 11'h001) -
                   11'(({1'b0, wd_top(q.cr)} + 11'h001) >> 2)); // R3
        if (pre_tick && wd_en)
        begin
            if (wd_last)
            begin
                wd_fire  = 1'b1; // R1
                n.wd_cnt = 10'h000;
                n.armed  = 1'b0;
            end
            else
                n.wd_cnt = q.wd_cnt + 10'h001;
        end

        if (rs_wr && wd_en)
        begin
            if (wb != `WMC_KEY_FIRST && wb != `WMC_KEY_SECOND)
                wd_fire = 1'b1; // R2
            else if (q.windowed_watchdog && !in_win)
                wd_fire = 1'b1; // R3
            else if (wb == `WMC_KEY_FIRST)
                n.armed = 1'b1; // R4
            else if (q.armed)
            begin
                n.wd_cnt = 10'h000; // R20 R4
                n.armed  = 1'b0;
            end
        end

        // clock monitor counts pclk, so it runs with no crystal at all
        mact    = q.monitor_enable | q.monitor_force_on; // R14
        mon_new = 1'b0;
        if (!mact || xrise)
        begin
            n.mon_cnt  = 8'h00;
            n.mon_fail = 1'b0;
            if (xrise)
                n.limp = 1'b0;
        end
        else if (q.mon_cnt != MON_LAST)
            n.mon_cnt = q.mon_cnt + 8'h01;
        else if (!q.mon_fail)
        begin
            mon_new    = 1'b1; // R13
            n.mon_fail = 1'b1;
        end
        if (mon_new)
        begin
            if (no_limp_home)
                cm_fire = 1'b1; // R13
            else
                n.limp = 1'b1;
        end

        if (q.force_rst)
        begin
            if (wd_en)
                wd_fire = 1'b1; // R16
            if (mact)
                cm_fire = 1'b1; // R16
        end
        n.wd_rst = wd_fire & ~q.supervisor_reset_disable; // R17
        n.cm_rst = cm_fire & ~q.supervisor_reset_disable; // R17

        if (setup)
        begin
            n.prdata = 32'h0000_0000;
            case (idx)
                `WMC_IDX_PCTL:
                    n.prdata[7:0] = {q.periodic_irq_enable, q.swai, q.sdbg, 1'b0,
                                     q.byp, q.rtr};
                `WMC_IDX_PFLG:
                    n.prdata[`WMC_PF_FLAG] = q.flag;
                `WMC_IDX_WCTL:
                    n.prdata[7:0] = {q.monitor_enable, q.monitor_force_on, q.force_rst, q.windowed_watchdog,
                                     q.supervisor_reset_disable, q.cr};
                `WMC_IDX_SLOW:
                    n.prdata[5:0] = q.slow_div;
                default:
                    n.prdata = 32'h0000_0000;
            endcase
        end

        if (wr)
        begin
            case (idx)
                `WMC_IDX_PCTL:
                begin
                    n.periodic_irq_enable = wb[`WMC_PC_IE];
                    n.rtr  = wb[2:0]; // R7
                    if (special_mode || !q.once_p)
                    begin
                        n.swai = wb[`WMC_PC_SWAI]; // R10
                        n.sdbg = wb[`WMC_PC_SDBG]; // R11
                    end
                    if (special_mode)
                        n.byp = wb[`WMC_PC_BYP]; // R12
                    else
                        n.once_p = 1'b1;
                end
                `WMC_IDX_PFLG:
                    if (wb[`WMC_PF_FLAG])
                        n.flag = 1'b0; // R9
                `WMC_IDX_WCTL:
                begin
                    n.monitor_enable = wb[`WMC_WC_CME];
                    if (special_mode || !q.once_w)
                    begin
                        n.monitor_force_on = wb[`WMC_WC_MONITOR_FORCE_ON]; // R14
                        n.windowed_watchdog = wb[`WMC_WC_WIN]; // R3
                        n.cr   = wb[2:0]; // R6
                    end
                    if (special_mode)
                    begin
                        n.force_rst = wb[`WMC_WC_FORCE]; // R16
                        n.supervisor_reset_disable      = wb[`WMC_WC_SUPERVISOR_RESET_DISABLE]; // R17
                    end
                    else
                        n.once_w = 1'b1;
                end
                `WMC_IDX_SLOW:
                    n.slow_div = wb[5:0];
                default:
                    n.armed = n.armed;
            endcase
        end

        // a new period beats a clear in the same cycle
        if (rti_hit)
            n.flag = 1'b1; // R8
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q          <= '0;
            q.cr       <= `WMC_RST_RATE;
            q.slow_div <= `WMC_RST_SLOW;
        end
        else
            q <= n;
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    bad_key_reset_a: assert property ( // R2
        rs_wr && wd_en && !q.supervisor_reset_disable && wb != `WMC_KEY_FIRST &&
        wb != `WMC_KEY_SECOND |=> watchdog_reset)
        else $error("bad restart key did not reset");

    early_window_a: assert property ( // R3
        rs_wr && wd_en && q.windowed_watchdog && !in_win && !q.supervisor_reset_disable
        |=> watchdog_reset)
        else $error("early restart in window mode did not reset");

    key_restart_a: assert property ( // R20
        rs_wr && wd_en && q.armed && wb == `WMC_KEY_SECOND &&
        (!q.windowed_watchdog || in_win) |=> q.wd_cnt == 10'h000 && !q.armed)
        else $error("key pair did not restart the count");

    flag_set_a: assert property ( // R8
        rti_hit |=> q.flag ##0 periodic_irq_request == q.periodic_irq_enable)
        else $error("periodic flag not set at period end");

    flag_clear_a: assert property ( // R9
        wr && idx == `WMC_IDX_PFLG && wb[`WMC_PF_FLAG] && !rti_hit
        |=> !q.flag)
        else $error("flag not cleared by write of one");

    wait_halt_a: assert property ( // R10
        wait_state && q.swai |=> q.pre == $past(q.pre) &&
        q.wd_cnt == $past(q.wd_cnt))
        else $error("timers ran while halted in wait");

    disable_reset_a: assert property ( // R17
        q.supervisor_reset_disable |=> !watchdog_reset && !monitor_reset)
        else $error("failure reset while resets disabled");

    cme_load_a: assert property ( // R15
        !q.init |=> q.monitor_enable == $past(pll_supply_sense))
        else $error("monitor enable not loaded from supply sense");

    rate_once_a: assert property ( // R6
        q.once_w && !special_mode |=> q.cr == $past(q.cr))
        else $error("watchdog rate changed after first write");

    monitor_fail_a: assert property ( // R13
        mon_new && !q.supervisor_reset_disable |=> (no_limp_home ? monitor_reset : limp_home))
        else $error("missing crystal not acted upon");

    debug_halt_a: assert property ( // R11
        debug_state && q.sdbg |=> q.pre == $past(q.pre) &&
        q.wd_cnt == $past(q.wd_cnt))
        else $error("timers ran while halted in debug");

    force_reset_a: assert property ( // R16
        q.force_rst && wd_en && !q.supervisor_reset_disable |=> watchdog_reset)
        else $error("forced watchdog reset missing");

    timeout_reset_a: assert property ( // R1
        pre_tick && wd_en && wd_last && !q.supervisor_reset_disable |=> watchdog_reset)
        else $error("watchdog expiry did not reset");

    good_key_quiet_a: assert property ( // R4
        rs_wr && wd_en && (wb == `WMC_KEY_FIRST || wb == `WMC_KEY_SECOND)
        && (!q.windowed_watchdog || in_win) && !pre_tick && !q.force_rst
        |=> !watchdog_reset)
        else $error("valid restart key caused a reset");

    monitor_off_a: assert property ( // R14
        !(q.monitor_enable || q.monitor_force_on) |=> !monitor_reset)
        else $error("monitor reset while monitor inactive");

    limp_exit_a: assert property ( // R19
        q.limp && xrise |=> !limp_home)
        else $error("limp-home kept after crystal edge");
endmodule : wmc_supervisor

// ### tb/tb_wmc_supervisor.sv
// self-checking bench of the watchdog, periodic timer and clock monitor
`timescale 1ns/1ps
module tb_wmc_supervisor;
    localparam logic [11:0] a_pc = 12'h050;
    localparam logic [11:0] a_pf = 12'h054;
    localparam logic [11:0] a_wc = 12'h058;
    localparam logic [11:0] a_rs = 12'h05c;
    localparam logic [11:0] a_sd = 12'h060;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, wd_rst, cm_rst, limp, irq, err;
    logic        xtal = 1'b0, pllc = 1'b0, xrun = 1'b1;
    logic        sense = 1'b1, spec = 1'b1, nolh = 1'b1;
    logic        wst = 1'b0, dbg = 1'b0;
    logic [7:0]  lfsr = 8'h16, rd;
    logic [7:0]  ftab [5] = '{8'h20, 8'h23, 8'ha0, 8'ha3, 8'hab};
    int          error_cnt = 0, check_count = 0;
    int          wd_n = 0, cm_n = 0, cyc = 0, wb, cb, t0, t1;

    wmc_supervisor dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .crystal_clock(xtal), .pll_output_clock(pllc),
        .pll_supply_sense(sense), .special_mode(spec),
        .wait_state(wst), .debug_state(dbg), .no_limp_home(nolh),
        .watchdog_reset(wd_rst), .monitor_reset(cm_rst),
        .limp_home(limp), .periodic_irq_request(irq)
    );

    always #5 pclk = ~pclk;

    // crystal rises every 8 cycles; stands still while stopped
    always @(posedge pclk)
    begin
        cyc  <= cyc + 1;
        wd_n <= wd_n + int'(wd_rst === 1'b1);
        cm_n <= cm_n + int'(cm_rst === 1'b1);
        if (cyc % 4 == 0 && xrun)
            xtal <= ~xtal;
        if (cyc % 3 == 0)
            pllc <= ~pllc;
    end

    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nx

    // bypass: one prescaler tick is 64 cycles times the slow ratio
    function automatic int per(input int r, input int s);
        return (64 << (r - 1)) * (s == 0 ? 1 : 2 * s);
    endfunction : per

    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task automatic chk(input string s, input logic [7:0] e,
                       input logic [7:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", s, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge pclk);
        end
        rd  = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 50)
        begin
            chk("pready", 8'h01, 8'h00);
            end_sim;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string s, input logic [11:0] a,
                       input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(s, e, rd);
    endtask : rdc

    task automatic wirq(output int t);
        int n;
        n = 0;
        @(negedge pclk);
        while (irq !== 1'b1 && n < 3000)
        begin
            n++;
            @(negedge pclk);
        end
        t = cyc;
        @(posedge pclk);
        if (n >= 3000)
        begin
            chk("irq wait", 8'h01, 8'h00);
            end_sim;
        end
    endtask : wirq

    task automatic kick;
        wr(a_rs, 8'h55);
        wr(a_rs, 8'haa);
    endtask : kick

    task automatic mark;
        wb = wd_n;
        cb = cm_n;
    endtask : mark

    task automatic rst(input logic sp, input logic se);
        presetn <= 1'b0;
        spec    <= sp;
        sense   <= se;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : rst

    initial
    begin
        int i;
        int r;
        int s;
        logic [7:0] v;
        rst(1'b1, 1'b1);
        rdc("pctl rst", a_pc, 8'h00);
        rdc("wctl rst", a_wc, 8'h8f);
        apb(1'b0, 12'h3f0, 8'h00);
        chk("unmapped", 8'h01, {7'h00, err});
        for (i = 0; i < 3; i++)
        begin
            lfsr = nx(lfsr);
            r = 1 + int'(lfsr[0]);
            s = int'(lfsr[2:1]) % 3;
            wr(a_sd, 8'(s));
            wr(a_pc, 8'h88 | 8'(r));
            wr(a_pf, 8'h80);
            wirq(t0);
            wr(a_pf, 8'h00);
            rdc("flag hold", a_pf, 8'h80);
            wr(a_pf, 8'h80);
            rdc("flag clr", a_pf, 8'h00);
            wirq(t1);
            v = 8'((t1 - t0 - per(r, s)) inside {[-2:2]});
            chk("period", 8'h01, v);
        end
        wr(a_sd, 8'h00);
        wr(a_pc, 8'h09);
        repeat (200) @(posedge pclk);
        chk("masked", 8'h00, {7'h00, irq});
        for (i = 0; i < 2; i++)
        begin
            wst <= (i == 0);
            dbg <= (i == 1);
            wr(a_pc, i == 0 ? 8'hc9 : 8'ha9);
            wr(a_pf, 8'h80);
            repeat (300) @(posedge pclk);
            chk("halted", 8'h00, {7'h00, irq});
            wst <= 1'b0;
            dbg <= 1'b0;
            wirq(t0);
        end
        wr(a_wc, 8'h02);
        kick();
        mark();
        for (i = 0; i < 6; i++)
        begin
            repeat (100) @(posedge pclk);
            kick();
        end
        repeat (185) @(posedge pclk);
        chk("kept", 8'h00, 8'(wd_n - wb));
        repeat (90) @(posedge pclk);
        chk("timeout", 8'h01, 8'(wd_n > wb));
        for (i = 0; i < 3; i++)
        begin
            lfsr = nx(lfsr);
            v = (lfsr == 8'h55 || lfsr == 8'haa) ? 8'h00 : lfsr;
            kick();
            mark();
            wr(a_rs, v);
            repeat (2) @(posedge pclk);
            chk("bad key", 8'h01, 8'(wd_n - wb));
        end
        wr(a_wc, 8'h0a);
        mark();
        wr(a_rs, 8'h13);
        repeat (3) @(posedge pclk);
        chk("disabled", 8'h00, 8'(wd_n - wb));
        for (i = 0; i < 2; i++)
        begin
            wr(a_wc, 8'h03);
            kick();
            wr(a_wc, 8'h13);
            mark();
            repeat (i * 820) @(posedge pclk);
            wr(a_rs, 8'h55);
            repeat (2) @(posedge pclk);
            chk("window", 8'(i == 0), 8'(wd_n - wb));
        end
        wr(a_rs, 8'h55);
        wr(a_rs, 8'haa);
        chk("in window", 8'h00, 8'(wd_n - wb));
        wr(a_rs, 8'h55);
        repeat (2) @(posedge pclk);
        chk("closed", 8'h01, 8'(wd_n - wb));
        for (i = 0; i < 5; i++)
        begin
            v = ftab[i];
            wr(a_wc, v);
            // the old setting still pulses once after the write edge
            repeat (2) @(posedge pclk);
            mark();
            repeat (4) @(posedge pclk);
            chk("force wd", 8'(v[2:0] != 3'h0 && !v[3]), 8'(wd_n > wb));
            chk("force cm", 8'(v[7] && !v[3]), 8'(cm_n > cb));
        end
        wr(a_wc, 8'h80);
        mark();
        xrun <= 1'b0;
        repeat (260) @(posedge pclk);
        chk("mon rst", 8'h01, 8'(cm_n > cb));
        nolh <= 1'b0;
        xrun <= 1'b1;
        repeat (20) @(posedge pclk);
        xrun <= 1'b0;
        repeat (260) @(posedge pclk);
        chk("limp", 8'h01, {7'h00, limp});
        wr(a_pf, 8'h80);
        wirq(t0);
        xrun <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("limp off", 8'h00, {7'h00, limp});
        // normal mode: write-once and special-only fields
        rst(1'b0, 1'b0);
        nolh <= 1'b1;
        rdc("wctl nrm", a_wc, 8'h07);
        wr(a_pc, 8'h6b);
        rdc("pctl once", a_pc, 8'h63);
        wr(a_pc, 8'h05);
        rdc("pctl lock", a_pc, 8'h65);
        wr(a_wc, 8'h5a);
        wr(a_wc, 8'h00);
        rdc("wctl lock", a_wc, 8'h52);
        mark();
        xrun <= 1'b0;
        repeat (260) @(posedge pclk);
        chk("forced mon", 8'h01, 8'(cm_n > cb));
        end_sim;
    end
endmodule : tb_wmc_supervisor
